// ==== core/emb_cfg.svh ====
// What this block does
// - address strobe pulses low once per external access, not for on-chip ones
// - address, direction, space valid at strobe rise
// - software float of strobes, direction and both ports together; space select is never floated
// - write data valid by data strobe fall
// - data strobe high for on-chip accesses
// - direction low only for external writes
// - reset fetches start vector from 00h, 01h
// - port 0 address then data, port 1 high
// - two separate 64K spaces, program and data
// - on-chip program memory at 0 to 3FFFh
// - otp variant reserves top 64 program bytes
// - nonvolatile data memory at 0 to 1FFh
// - on-chip ram at 200h to 2FFh
// - program fetches above 16K go external
// - space select output for external decode
//
// Purpose: constants of the external memory bus interface
// Assumes: one 10 MHz clock, synchronous reset
// Notes:   addresses are byte addresses in each space
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH
`define EMB_PROG_INT_TOP   16'h3FFF
`define EMB_OTP_RSVD_BYTES 16'h0040
`define EMB_NVM_TOP        16'h01FF
`define EMB_RAM_BASE       16'h0200
`define EMB_RAM_TOP        16'h02FF
`define EMB_VEC_HI_ADDR    16'h0000
`define EMB_VEC_LO_ADDR    16'h0001
`endif

// ==== core/emb_pkg.sv ====
// Purpose: types of the external memory bus interface
// Assumes: included config header for numbers
// Notes:   none
package emb_pkg;
  typedef enum logic [2:0] {
    EMB_IDLE  = 3'h0,
    EMB_ADDR  = 3'h1,
    EMB_LATCH = 3'h3,
    EMB_DATA  = 3'h2,
    EMB_END   = 3'h6
  } emb_state_t;
  typedef enum logic [1:0] {
    EMB_TGT_EXT  = 2'h0,
    EMB_TGT_PROG = 2'h1,
    EMB_TGT_NVM  = 2'h2,
    EMB_TGT_RAM  = 2'h3
  } emb_tgt_t;
endpackage

// ==== core/emb_decode.sv ====
// Purpose: memory space decode
// Assumes: combinational
// Notes:   none
`timescale 1ns/1ns
`default_nettype none
`include "emb_cfg.svh"
module emb_decode #(
  parameter bit OTP = 1'b0
) (
  input  wire logic       space_prog,
  input  wire logic [15:0] addr,
  output emb_pkg::emb_tgt_t tgt,
  output logic            rsvd
);
  always_comb begin
    tgt  = emb_pkg::EMB_TGT_EXT;
    rsvd = 1'b0;
    if (space_prog) begin
      if (addr <= `EMB_PROG_INT_TOP) begin
        tgt = emb_pkg::EMB_TGT_PROG;
        rsvd = OTP && (addr > (`EMB_PROG_INT_TOP - `EMB_OTP_RSVD_BYTES));
      end
    end else begin
      if (addr <= `EMB_NVM_TOP) begin
        tgt = emb_pkg::EMB_TGT_NVM;
      end else if (addr >= `EMB_RAM_BASE && addr <= `EMB_RAM_TOP) begin
        tgt = emb_pkg::EMB_TGT_RAM;
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/emb_bus.sv ====
// Purpose: external memory bus sequencer and space decode
// Assumes: one requester, inputs synchronous to ref_clk
// Notes:   internal accesses take one cycle, external five
`timescale 1ns/1ns
`default_nettype none
`include "emb_cfg.svh"
module emb_bus #(
  parameter bit OTP = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_prog,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  output logic             rsp_rsvd,
  output logic             vec_done,
  output logic [15:0]      vec_addr,
  input  wire logic        bus_float,
  output logic             int_sel,
  output logic             int_prog,
  output logic             int_nvm,
  output logic             int_we,
  output logic [15:0]      int_addr,
  output logic [7:0]       int_wdata,
  input  wire logic [7:0]  int_rdata,
  output logic             address_strobe_n,
  output logic             address_strobe_oe_n,
  output logic             data_strobe_n,
  output logic             data_strobe_oe_n,
  output logic             rw,
  output logic             rw_oe_n,
  output logic             space_data,
  output logic [7:0]       p0_out,
  output logic [7:0]       p0_oe_n,
  input  wire logic [7:0]  p0_in,
  output logic [7:0]       p1_out,
  output logic [7:0]       p1_oe_n
);
  // ==========================================================
  // state
  typedef struct packed {
    emb_pkg::emb_state_t st;
    logic [1:0]  vec;
    logic        prog;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        as_n;
    logic        ds_n;
    logic        rw;
    logic        sp_d;
    logic        p0_drv;
    logic [7:0]  p0;
    logic [7:0]  p1;
    logic        rv;
    logic [7:0]  rd;
    logic        rsvd;
    logic [15:0] vaddr;
    logic        vdone;
  } emb_regs_t;
  emb_regs_t r_r;
  emb_regs_t r_nxt;
  emb_pkg::emb_tgt_t tgt;
  logic rsvd_hit;
  logic        cur_prog;
  logic [15:0] cur_addr;
  logic        cur_wr;
  logic        take;
  // ==========================================================
  // decode
  emb_decode #(.OTP(OTP)) u_dec (
    .space_prog (cur_prog),
    .addr       (cur_addr),
    .tgt        (tgt),
    .rsvd       (rsvd_hit)
  );
  always_comb begin
    cur_prog = r_r.vdone ? req_prog : 1'b1;
    cur_addr = r_r.vdone ? req_addr :
               (r_r.vec[0] ? `EMB_VEC_LO_ADDR : `EMB_VEC_HI_ADDR);
    cur_wr   = r_r.vdone ? req_write : 1'b0;
  end
  assign req_ready = r_r.vdone && (r_r.st == emb_pkg::EMB_IDLE);
  assign take = (r_r.st == emb_pkg::EMB_IDLE) &&
                (!r_r.vdone || req_valid);
  // ==========================================================
  // sequencer
  always_comb begin
    r_nxt    = r_r;
    r_nxt.rv = 1'b0;
    int_sel  = 1'b0;
    unique case (r_r.st)
      emb_pkg::EMB_IDLE: begin
        if (take) begin
          r_nxt.prog  = cur_prog;
          r_nxt.wr    = cur_wr;
          r_nxt.addr  = cur_addr;
          r_nxt.wdata = req_wdata;
          if (tgt != emb_pkg::EMB_TGT_EXT) begin
            int_sel    = 1'b1;
            r_nxt.rv   = 1'b1;
            r_nxt.rd   = int_rdata;
            r_nxt.rsvd = rsvd_hit;
            r_nxt.st   = emb_pkg::EMB_END;
          end else begin
            r_nxt.as_n   = 1'b0;
            r_nxt.rw     = ~cur_wr;
            r_nxt.sp_d   = ~cur_prog;
            r_nxt.p0_drv = 1'b1;
            r_nxt.p0     = cur_addr[7:0];
            r_nxt.p1     = cur_addr[15:8];
            r_nxt.st     = emb_pkg::EMB_ADDR;
          end
        end
      end
      emb_pkg::EMB_ADDR: begin
        r_nxt.as_n = 1'b1;
        r_nxt.st   = emb_pkg::EMB_LATCH;
      end
      emb_pkg::EMB_LATCH: begin
        r_nxt.p0_drv = r_r.wr;
        r_nxt.p0     = r_r.wr ? r_r.wdata : r_r.p0;
        r_nxt.st     = emb_pkg::EMB_DATA;
      end
      emb_pkg::EMB_DATA: begin
        r_nxt.ds_n = 1'b0;
        r_nxt.st   = emb_pkg::EMB_END;
      end
      emb_pkg::EMB_END: begin
        if (!r_r.ds_n) begin
          r_nxt.rd   = p0_in;
          r_nxt.rv   = 1'b1;
          r_nxt.rsvd = 1'b0;
        end
        r_nxt.ds_n   = 1'b1;
        r_nxt.rw     = 1'b1;
        r_nxt.p0_drv = 1'b0;
        r_nxt.st     = emb_pkg::EMB_IDLE;
      end
      default: r_nxt.st = emb_pkg::EMB_IDLE;
    endcase
    if (r_nxt.rv && !r_r.vdone) begin
      if (!r_r.vec[0]) begin
        r_nxt.vaddr[15:8] = r_nxt.rd;
        r_nxt.vec = 2'h1;
      end else begin
        r_nxt.vaddr[7:0] = r_nxt.rd;
        r_nxt.vdone = 1'b1;
        r_nxt.vec = 2'h2;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_r <= '{st: emb_pkg::EMB_IDLE, vec: 2'h0, prog: 1'b1, wr: 1'b0,
               addr: 16'h0000, wdata: 8'h00, as_n: 1'b1, ds_n: 1'b1,
               rw: 1'b1, sp_d: 1'b0, p0_drv: 1'b0, p0: 8'h00,
               p1: 8'h00, rv: 1'b0, rd: 8'h00, rsvd: 1'b0,
               vaddr: 16'h0000, vdone: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end
  // ==========================================================
  // outputs
  assign int_prog  = (tgt == emb_pkg::EMB_TGT_PROG);
  assign int_nvm   = (tgt == emb_pkg::EMB_TGT_NVM);
  assign int_we    = int_sel && cur_wr;
  assign int_addr  = cur_addr;
  assign int_wdata = req_wdata;
  assign rsp_valid = r_r.rv && r_r.vdone && (r_r.vec == 2'h2);
  assign rsp_rdata = r_r.rd;
  assign rsp_rsvd  = r_r.rsvd;
  assign vec_done  = r_r.vdone;
  assign vec_addr  = r_r.vaddr;
  assign address_strobe_n = r_r.as_n;
  assign data_strobe_n    = r_r.ds_n;
  assign rw               = r_r.rw;
  assign space_data       = r_r.sp_d;
  assign p0_out           = r_r.p0;
  assign p1_out           = r_r.p1;
  assign address_strobe_oe_n = bus_float;
  assign data_strobe_oe_n    = bus_float;
  assign rw_oe_n             = bus_float;
  assign p1_oe_n             = {8{bus_float}};
  assign p0_oe_n             = {8{bus_float || !r_r.p0_drv}};
  // ==========================================================
  // checks
  property p_as_pulse;
    @(posedge ref_clk) disable iff (rst)
      $fell(address_strobe_n) |=> address_strobe_n;
  endproperty
  a_as_pulse: assert property (p_as_pulse) else $error("as wide");
  property p_as_valid;
    @(posedge ref_clk) disable iff (rst)
      $rose(address_strobe_n) |-> $stable(p1_out) && $stable(rw)
        && $stable(space_data) && $stable(p0_out);
  endproperty
  a_as_valid: assert property (p_as_valid) else $error("addr moved");
  property p_float;
    @(posedge ref_clk) disable iff (rst)
      bus_float |-> address_strobe_oe_n && data_strobe_oe_n && rw_oe_n
                    && (p1_oe_n == 8'hFF) && (p0_oe_n == 8'hFF);
  endproperty
  a_float: assert property (p_float) else $error("not floated");
  property p_wdata;
    @(posedge ref_clk) disable iff (rst)
      $fell(data_strobe_n) && !rw |-> p0_out == r_r.wdata && r_r.p0_drv;
  endproperty
  a_wdata: assert property (p_wdata) else $error("wdata late");
  property p_int_ds;
    @(posedge ref_clk) disable iff (rst)
      int_sel |=> data_strobe_n && address_strobe_n;
  endproperty
  a_int_ds: assert property (p_int_ds) else $error("ds on int");
  property p_rw;
    @(posedge ref_clk) disable iff (rst)
      !rw |-> r_r.wr && r_r.st != emb_pkg::EMB_IDLE;
  endproperty
  a_rw: assert property (p_rw) else $error("rw low");
  sequence s_first_vec;
    !vec_done ##1 !vec_done;
  endsequence
  property p_vec;
    @(posedge ref_clk) disable iff (rst)
      s_first_vec |-> !req_ready;
  endproperty
  a_vec: assert property (p_vec) else $error("ready early");
  property p_vec_addr;
    @(posedge ref_clk) disable iff (rst)
      !vec_done && int_sel |-> int_prog && !int_we
        && (int_addr[15:1] == 15'h0000);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad vector");
  property p_ext_prog;
    @(posedge ref_clk) disable iff (rst)
      take && cur_prog && cur_addr > `EMB_PROG_INT_TOP
        |=> !address_strobe_n && !space_data;
  endproperty
  a_ext_prog: assert property (p_ext_prog) else $error("no ext");
  property p_ext_data;
    @(posedge ref_clk) disable iff (rst)
      take && !cur_prog && cur_addr > `EMB_RAM_TOP
        |=> !address_strobe_n && space_data;
  endproperty
  a_ext_data: assert property (p_ext_data) else $error("no data");
endmodule
`default_nettype wire

// ==== verification/emb_mem_model.sv ====
// Purpose: external program and data memory on the bus
// Assumes: address latched on address strobe rise
// Notes:   keyed by space select and low seven address bits
`timescale 1ns/1ns
`default_nettype none
module emb_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        address_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        rw,
  input  wire logic        space_data,
  input  wire logic [7:0]  p0_out,
  input  wire logic [7:0]  p0_oe_n,
  input  wire logic [7:0]  p1_out,
  output logic      [7:0]  p0_in,
  output logic      [15:0] lat_addr,
  output logic             lat_space
);
  // ==========================================
  // storage and latch
  logic [7:0] mem [0:255];
  logic [7:0] last;
  logic [7:0] key;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hC3;
    end
    last = 8'h00;
  end
  assign key = {lat_space, lat_addr[6:0]};
  always @(posedge address_strobe_n) begin
    lat_addr  <= {p1_out, p0_out};
    lat_space <= space_data;
  end
  always @(negedge data_strobe_n) begin
    if (!rw) begin
      mem[key] <= p0_out;
    end
  end
  assign p0_in = (p0_oe_n[0] === 1'b0) ? p0_out :
                 (!data_strobe_n && rw) ? mem[key] : ~last;
  always @(posedge ref_clk) begin
    last <= p0_in;
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench of the external memory bus
// Assumes: on-chip memory reads back address low byte xor 40
// Notes:   reserved flag enabled
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ==========================================
  // signals and instances
  logic        ref_clk, rst, req_valid, req_prog, req_write, bus_float;
  logic        req_ready, rsp_valid, rsp_rsvd, vec_done, int_sel;
  logic        int_prog, int_nvm, int_we, rw, rw_oe_n, space_data;
  logic        address_strobe_n, address_strobe_oe_n, lat_space;
  logic        data_strobe_n, data_strobe_oe_n;
  logic [7:0]  req_wdata, rsp_rdata, int_wdata, int_rdata, p0_in;
  logic [7:0]  p0_out, p0_oe_n, p1_out, p1_oe_n;
  logic [15:0] req_addr, vec_addr, int_addr, lat_addr;
  int          miscompares = 0;
  int          n_checks = 0;
  assign int_rdata = int_addr[7:0] ^ 8'h40;
  emb_bus #(.OTP(1'b1)) uut (
    .ref_clk, .rst, .req_valid, .req_ready, .req_prog, .req_write,
    .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_rsvd, .vec_done,
    .vec_addr, .bus_float, .int_sel, .int_prog, .int_nvm, .int_we,
    .int_addr, .int_wdata, .int_rdata, .address_strobe_n,
    .address_strobe_oe_n, .data_strobe_n, .data_strobe_oe_n, .rw,
    .rw_oe_n, .space_data, .p0_out, .p0_oe_n, .p0_in, .p1_out, .p1_oe_n
  );
  emb_mem_model mem (
    .ref_clk, .address_strobe_n, .data_strobe_n, .rw, .space_data,
    .p0_out, .p0_oe_n, .p1_out, .p0_in, .lat_addr, .lat_space
  );
  // ==========================================
  // checking and closing
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic hang(input string m);
    chk(1'b0, m);
    report_and_stop();
  endtask
  // one access; d is write data or expected read data
  task automatic acc(input logic pg, input logic wr, input logic [15:0] a,
                     input logic [7:0] d, input logic ext);
    int n;
    int as_lo;
    int ds_lo;
    int rw_lo;
    as_lo = 0;
    ds_lo = 0;
    rw_lo = 0;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_prog  <= pg;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > 50) hang("request not taken");
    end while (req_ready !== 1'b1);
    chk(int_sel === ~ext && int_we === (~ext & wr), "on-chip strobe");
    chk(int_prog === (~ext & pg), "program target");
    chk(int_nvm === (~ext & ~pg & (a <= 16'h01FF)), "nvm target");
    chk(ext || (int_addr === a && int_wdata === d), "on-chip addr");
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      as_lo += (address_strobe_n === 1'b0);
      ds_lo += (data_strobe_n === 1'b0);
      rw_lo += (rw === 1'b0);
      if (n > 20) hang("no response");
    end while (rsp_valid !== 1'b1);
    chk(as_lo == (ext ? 1 : 0), "address strobe count");
    chk(ds_lo == (ext ? 1 : 0), "data strobe count");
    chk((rw_lo > 0) == (ext && wr), "direction line");
    chk(rsp_rsvd === (pg && a >= 16'h3FC0 && a <= 16'h3FFF), "rsvd");
    if (ext) chk(lat_addr === a && lat_space === ~pg, "address");
    if (!wr) chk(rsp_rdata === d, "read data");
  endtask
  // ==========================================
  // scenarios
  task automatic t_vec();
    int n;
    int ds_lo;
    n = 0;
    ds_lo = 0;
    do begin
      @(negedge ref_clk);
      n++;
      ds_lo += (data_strobe_n === 1'b0);
      if (n > 50) hang("vector fetch stuck");
    end while (vec_done !== 1'b1);
    chk(vec_addr === 16'h4041, "start vector");
    chk(ds_lo == 0, "strobe during vector fetch");
  endtask
  task automatic t_map();
    logic [15:0] a [9] = '{16'h3FBF, 16'h3FC0, 16'h3FFF, 16'h4000,
      16'h01FF, 16'h0200, 16'h02FF, 16'h0300, 16'hFFFF};
    logic [8:0]  p = 9'b1_0000_1111;
    logic [8:0]  e = 9'b1_1000_1000;
    logic [7:0]  x;
    for (int i = 0; i < 9; i++) begin
      x = e[i] ? ({~p[i], a[i][6:0]} ^ 8'hC3) : (a[i][7:0] ^ 8'h40);
      acc(p[i], 1'b0, a[i], x, e[i]);
    end
  endtask
  task automatic t_wr();
    acc(1'b1, 1'b1, 16'h4005, 8'h11, 1'b1);
    acc(1'b0, 1'b1, 16'h4005, 8'h22, 1'b1);
    acc(1'b1, 1'b0, 16'h4005, 8'h11, 1'b1);
    acc(1'b0, 1'b0, 16'h4005, 8'h22, 1'b1);
    acc(1'b0, 1'b1, 16'h0210, 8'h99, 1'b0);
  endtask
  task automatic t_float();
    @(posedge ref_clk);
    bus_float <= 1'b1;
    @(negedge ref_clk);
    chk({address_strobe_oe_n, data_strobe_oe_n, rw_oe_n, p0_oe_n, p1_oe_n}
        === {19{1'b1}}, "bus not floated");
    @(posedge ref_clk);
    bus_float <= 1'b0;
    @(negedge ref_clk);
    chk({address_strobe_oe_n, data_strobe_oe_n, rw_oe_n, p1_oe_n}
        === 11'h000, "bus still floated");
    acc(1'b1, 1'b0, 16'h4005, 8'h11, 1'b1);
  endtask
  // ==========================================
  // clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_prog = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    bus_float = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_vec();
    t_map();
    t_wr();
    t_float();
    report_and_stop();
  end
endmodule
`default_nettype wire
